// ### shared/watchdog_pkg.sv
// Purpose: Constants shared by the system watchdog
// Assumes: 100 MHz system clock
// Notes:   Times are in their own units; counts derive from the clock rate
package watchdog_pkg;
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          SECOND_S      = 1;
   localparam int          SEC_CYCLES    = CLK_HZ * SECOND_S;
   localparam int          MIN_SECONDS   = 60;
   localparam int          TICK_W        = 8;
   localparam logic [7:0]  TICKS_OFF     = 8'h00;
   localparam logic [7:0]  TICKS_ONE     = 8'h01;
   localparam logic        UNIT_SECOND   = 1'h0;
   localparam logic        UNIT_MINUTE   = 1'h1;
   localparam int          RESET_PULSE_CYCLES = 16;
endpackage

// ### hdl/system_watchdog.sv
// Purpose: System watchdog countdown with second or minute ticks
// Assumes: Commands are one-cycle pulses synchronous to clk_sys
// Notes:   Counts in whole ticks; the first tick arrives one full tick after the load
`timescale 1ns/1ns
module system_watchdog #(
   parameter int SEC_CYCLES   = watchdog_pkg::SEC_CYCLES,
   parameter int MIN_SECONDS  = watchdog_pkg::MIN_SECONDS,
   parameter int PULSE_CYCLES = watchdog_pkg::RESET_PULSE_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       set_timeout_operation,
   input  wire logic [7:0] timeout_ticks,
   input  wire logic       timeout_unit,
   input  wire logic       start_countdown_command,
   input  wire logic       refresh_countdown_command,
   input  wire logic       halt_countdown_command,
   output logic            running,
   output logic [7:0]      ticks_left,
   output logic            system_reset
);
   logic [7:0]  reload_q;
   logic        unit_q;
   logic        run_q;
   logic [7:0]  count_q;
   logic [31:0] pre_q;
   logic [7:0]  sec_q;
   logic        sec_tick;
   logic        min_tick;
   logic        unit_tick;
   logic        expire;
   logic [7:0]  pulse_q;
   logic        load;

   // Any command that restarts the count also restarts the prescaler
   // Refused starts restart it too; harmless, since the count is stopped then
   assign load = start_countdown_command || refresh_countdown_command ||
                 (set_timeout_operation && timeout_ticks != watchdog_pkg::TICKS_OFF);

   // Programmed timeout and unit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reload_q <= watchdog_pkg::TICKS_OFF;
         unit_q   <= watchdog_pkg::UNIT_SECOND;
      end else if (set_timeout_operation) begin
         reload_q <= timeout_ticks;
         unit_q   <= timeout_unit;
      end
   end

   // Prescaler restarts on every load so a tick is never shortened
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
         sec_q <= '0;
      end else if (load || !run_q) begin
         pre_q <= '0;
         sec_q <= '0;
      end else if (sec_tick) begin
         pre_q <= '0;
         sec_q <= min_tick ? 8'h00 : sec_q + 8'h01;
      end else begin
         pre_q <= pre_q + 32'h1;
      end
   end
   assign sec_tick  = (pre_q == 32'(SEC_CYCLES - 1));
   assign min_tick  = sec_tick && (sec_q == 8'(MIN_SECONDS - 1));
   assign unit_tick = (unit_q == watchdog_pkg::UNIT_MINUTE) ? min_tick : sec_tick;

   // Run state and countdown
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_q   <= 1'b0;
         count_q <= watchdog_pkg::TICKS_OFF;
      end else if (halt_countdown_command ||
                   (set_timeout_operation && timeout_ticks == watchdog_pkg::TICKS_OFF)) begin
         run_q   <= 1'b0;
         count_q <= watchdog_pkg::TICKS_OFF;
      end else if (set_timeout_operation) begin
         run_q   <= 1'b1;
         count_q <= timeout_ticks;
      end else if ((start_countdown_command || refresh_countdown_command) &&
                   reload_q != watchdog_pkg::TICKS_OFF) begin
         run_q   <= 1'b1;
         count_q <= reload_q;
      end else if (run_q && unit_tick) begin
         count_q <= count_q - watchdog_pkg::TICKS_ONE;
         if (count_q == watchdog_pkg::TICKS_ONE) begin
            run_q <= 1'b0;
         end
      end
   end
   assign expire = run_q && unit_tick && count_q == watchdog_pkg::TICKS_ONE &&
                   !load && !halt_countdown_command && !set_timeout_operation;

   // Reset pulse of fixed width so the system sees a clean assertion
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pulse_q <= '0;
      end else if (expire) begin
         pulse_q <= 8'(PULSE_CYCLES);
      end else if (pulse_q != 8'h00) begin
         pulse_q <= pulse_q - 8'h01;
      end
   end

   assign system_reset = (pulse_q != 8'h00);
   assign running      = run_q;
   assign ticks_left   = count_q;

   // Checker helper: the pulse outlasts any plain repetition count
   // Assumes a timeout longer than the pulse, true for any real tick length
   logic [7:0] hi_cnt_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_cnt_q <= '0;
      end else if (system_reset) begin
         hi_cnt_q <= hi_cnt_q + 8'h01;
      end else begin
         hi_cnt_q <= '0;
      end
   end

   // Reset held over two edges, so the registers have surely been cleared
   // The first edge alone may still see power-up unknowns
   sequence s_held_reset;
      rst ##1 rst;
   endsequence

   // A tick that nothing else in the same cycle overrides
   sequence s_live_tick;
      running && unit_tick && !load && !halt_countdown_command && !set_timeout_operation;
   endsequence

   // The last tick of a countdown, which must end in a system reset
   sequence s_final_tick;
      running && unit_tick && ticks_left == watchdog_pkg::TICKS_ONE && !load &&
      !halt_countdown_command && !set_timeout_operation;
   endsequence

   // A start or refresh while no timeout has been programmed
   sequence s_empty_load;
      (start_countdown_command || refresh_countdown_command) &&
      reload_q == watchdog_pkg::TICKS_OFF && !set_timeout_operation;
   endsequence

   // A cycle of second-unit counting with no tick and no command
   sequence s_quiet_second;
      running && unit_q == watchdog_pkg::UNIT_SECOND && !sec_tick && !load &&
      !halt_countdown_command && !set_timeout_operation;
   endsequence

   // Reset and expiry
   chk_reset_clears: assert property (@(posedge clk_sys)
      s_held_reset |-> !running && ticks_left == watchdog_pkg::TICKS_OFF && !system_reset)
      else $error("reset left the watchdog active");

   chk_expiry_resets: assert property (@(posedge clk_sys) disable iff (rst)
      expire |=> system_reset [*2]) else $error("expiry did not raise reset");

   chk_final_tick: assert property (@(posedge clk_sys) disable iff (rst)
      s_final_tick |=> system_reset && !running && ticks_left == watchdog_pkg::TICKS_OFF)
      else $error("last tick did not expire");

   chk_pulse_width: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(system_reset) |-> hi_cnt_q == 8'(PULSE_CYCLES))
      else $error("reset pulse had the wrong width");

   chk_idle_no_reset: assert property (@(posedge clk_sys) disable iff (rst)
      !running && !system_reset |=> !system_reset) else $error("reset while stopped");

   // Commands
   chk_halt_no_reset: assert property (@(posedge clk_sys) disable iff (rst)
      halt_countdown_command |=> !running && !expire) else $error("halt did not stop");

   chk_zero_disables: assert property (@(posedge clk_sys) disable iff (rst)
      set_timeout_operation && timeout_ticks == watchdog_pkg::TICKS_OFF |=> !running)
      else $error("zero timeout left it running");

   chk_write_starts: assert property (@(posedge clk_sys) disable iff (rst)
      set_timeout_operation && timeout_ticks != watchdog_pkg::TICKS_OFF && !halt_countdown_command
      |=> running && ticks_left == $past(timeout_ticks)) else $error("nonzero write no start");

   chk_refresh_reload: assert property (@(posedge clk_sys) disable iff (rst)
      refresh_countdown_command && !set_timeout_operation && !halt_countdown_command &&
      reload_q != watchdog_pkg::TICKS_OFF |=> ticks_left == reload_q)
      else $error("refresh did not reload");

   chk_start_runs: assert property (@(posedge clk_sys) disable iff (rst)
      start_countdown_command && !set_timeout_operation && !halt_countdown_command &&
      reload_q != watchdog_pkg::TICKS_OFF |=> running) else $error("start did not run");

   chk_empty_ignored: assert property (@(posedge clk_sys) disable iff (rst)
      s_empty_load |=> !running) else $error("load with no timeout started it");

   chk_timeout_latched: assert property (@(posedge clk_sys) disable iff (rst)
      set_timeout_operation |=> reload_q == $past(timeout_ticks) && unit_q == $past(timeout_unit))
      else $error("timeout or unit not latched");

   // Tick rate
   chk_tick_decrement: assert property (@(posedge clk_sys) disable iff (rst)
      s_live_tick |=> ticks_left == $past(ticks_left) - watchdog_pkg::TICKS_ONE)
      else $error("tick did not decrement");

   chk_second_unit: assert property (@(posedge clk_sys) disable iff (rst)
      s_quiet_second |=> ticks_left == $past(ticks_left))
      else $error("second ticked early");

   chk_minute_unit: assert property (@(posedge clk_sys) disable iff (rst)
      unit_q && sec_tick && !min_tick && running && !load && !halt_countdown_command &&
      !set_timeout_operation |=> ticks_left == $past(ticks_left))
      else $error("minute ticked early");
endmodule // system_watchdog

// ### verif/tb_system_watchdog.sv
// Purpose: Self-checking bench for the system watchdog
// Assumes: Short prescaler counts
// Notes:   Expiry time allows two cycles of slack
`timescale 1ns/1ns
module tb_system_watchdog;
   logic       clk_sys = 0, rst = 1, set_op = 0, go_c = 0, ref_c = 0, halt_c = 0, unit = 0;
   logic [7:0] ticks = 8'h00, left;
   logic       running, sys_rst;
   int         error_cnt = 0, samples_checked = 0, seed = 41002, n, t;
   localparam int SEC_SIM = 10;
   localparam int MIN_SIM = 3;
   always #5 clk_sys = ~clk_sys;
   system_watchdog #(.SEC_CYCLES(SEC_SIM), .MIN_SECONDS(MIN_SIM)) system_watchdog_inst (
      .clk_sys(clk_sys), .rst(rst), .set_timeout_operation(set_op),
      .timeout_ticks(ticks), .timeout_unit(unit), .start_countdown_command(go_c),
      .refresh_countdown_command(ref_c), .halt_countdown_command(halt_c),
      .running(running), .ticks_left(left), .system_reset(sys_rst));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d wrong %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One-cycle pulse; outputs are settled when this returns
   task automatic cmd(input logic s, g, r, h, input logic [7:0] tk, input logic u);
      @(posedge clk_sys);
      {set_op, go_c, ref_c, halt_c, ticks, unit} <= {s, g, r, h, tk, u};
      @(posedge clk_sys);
      {set_op, go_c, ref_c, halt_c} <= 4'h0;
      #1;
   endtask
   function automatic int exp_cyc(int tk, logic u);
      return tk * SEC_SIM * (u ? MIN_SIM : 1);
   endfunction
   // Bounded wait, so a silent watchdog returns 2000
   task automatic expire(output int c);
      c = 0;
      while (sys_rst !== 1'b1 && c < 2000) begin
         @(posedge clk_sys);
         #1 c++;
      end
   endtask
   task automatic window(input int e);
      expire(n);
      chk(n >= e && n <= e + 2, 1'b1);
      n = 0;
      while (sys_rst === 1'b1 && n < 100) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk(16'(n), 16'(watchdog_pkg::RESET_PULSE_CYCLES));
      chk(running, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      #1 chk({running, sys_rst, left}, 8'h00);
      cmd(0, 1, 0, 0, 8'h00, 0);
      chk(running, 1'b0);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         t = 1 + ($random(seed) & 3);
         cmd(1, 0, 0, 0, t[7:0], i[0]);
         chk({running, left}, {1'b1, t[7:0]});
         window(exp_cyc(t, i[0]));
         $display("expiry test %0d done", i);
      end
      cmd(1, 0, 0, 0, 8'hff, 0);
      chk(left, 8'hff);
      cmd(1, 0, 0, 0, 8'h02, 0);
      cmd(0, 0, 0, 1, 8'h00, 0);
      chk(running, 1'b0);
      expire(n);
      chk(n == 2000, 1'b1);
      cmd(0, 1, 0, 0, 8'h00, 1);
      chk({running, left}, {1'b1, 8'h02});
      repeat (15) @(posedge clk_sys);
      cmd(0, 0, 1, 0, 8'h00, 1);
      chk(left, 8'h02);
      window(20);
      cmd(1, 0, 0, 0, 8'h02, 0);
      cmd(1, 0, 0, 0, 8'h00, 0);
      chk(running, 1'b0);
      expire(n);
      chk(n == 2000, 1'b1);
      $display("command test done");
      stop_test();
   end
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end
endmodule // tb_system_watchdog
